//--- hdl/fcr_pkg.sv
// fcr_pkg: constants for the field current regulator
// assumes one 25 MHz clock; registers are 32-bit wishbone words
package fcr_pkg;
    localparam int CLK_HZ          = 25_000_000;
    localparam int SECOND_S        = 1;
    localparam int SECOND_CYCLES   = CLK_HZ * SECOND_S;
    localparam int SAMPLE_HZ       = 5_000;
    localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_HZ;
    localparam int VAL_W           = 10;
    localparam logic [9:0]  VAL_MAX    = 10'h3E8;
    localparam logic [9:0]  FRONT_RST  = 10'h32F;
    localparam logic [9:0]  EMF_SP_RST = 10'h3E8;
    localparam logic [9:0]  MAXF1_RST  = 10'h3E8;
    localparam logic [9:0]  MAXF2_RST  = 10'h1F4;
    localparam logic [9:0]  MINF_RST   = 10'h1F4;
    localparam logic [7:0]  ECON_RST   = 8'h1E;
    localparam logic [7:0]  IRF_RST    = 8'h00;
    localparam int IR_SHIFT        = 11;
    localparam int KP_SHIFT        = 2;
    localparam int KI_SHIFT        = 4;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_EMF_SP = 8'h04;
    localparam logic [7:0] REG_MAXF1  = 8'h08;
    localparam logic [7:0] REG_MAXF2  = 8'h0C;
    localparam logic [7:0] REG_MINF   = 8'h10;
    localparam logic [7:0] REG_FRONT  = 8'h14;
    localparam logic [7:0] REG_ECON   = 8'h18;
    localparam logic [7:0] REG_IRF    = 8'h1C;
    localparam logic [7:0] REG_BEMF   = 8'h20;
    localparam logic [7:0] REG_DEMAND = 8'h24;
    localparam logic [7:0] REG_ANGLE  = 8'h28;
    localparam logic [7:0] REG_STATUS = 8'h2C;
    // control bit positions
    localparam int CTRL_SEL2   = 0;
    localparam int CTRL_AUTO   = 1;
    localparam int CTRL_DIRECT = 2;
    localparam int CTRL_ENABLE = 3;
    localparam int CTRL_PINSEL = 4;
    typedef enum logic [1:0] {FCR_IDLE, FCR_VOLT, FCR_CURR} fcr_state_e;
    function automatic logic [9:0] fcr_clamp(input logic signed [23:0] v,
                                             input logic [9:0] lo,
                                             input logic [9:0] hi);
        if (v > $signed({14'h0000, hi})) begin
            return hi;
        end else if (v < $signed({14'h0000, lo})) begin
            return lo;
        end
        return v[9:0];
    endfunction : fcr_clamp
endpackage : fcr_pkg

//--- hdl/fcr_tick.sv
// fcr_tick: one-cycle enable every DIV clocks
// assumes a synchronous active-low reset
`timescale 1ns/1ps
module fcr_tick #(
    parameter int DIV = 5000
) (
    input  wire logic clk_in,   // control clock
    input  wire logic rstn_in,  // synchronous reset, low active
    input  wire logic clear_in, // restart the count
    output logic      tick_out  // one-cycle pulse
);
    logic [31:0] count;
    wire         wrap = (count == 32'(DIV - 1));
    always_ff @(posedge clk_in) begin
        if (!rstn_in || clear_in || wrap) begin
            count <= '0;
        end else begin
            count <= count + 32'h1;
        end
    end
    always_ff @(posedge clk_in) begin
        tick_out <= rstn_in && !clear_in && wrap;
    end
endmodule : fcr_tick

//--- hdl/fcr_econ.sv
// fcr_econ: field economy delay, counts seconds after the drive stops
// assumes sec_tick_in pulses once a second
`timescale 1ns/1ps
module fcr_econ (
    input  wire logic       clk_in,     // control clock
    input  wire logic       rstn_in,    // synchronous reset, low active
    input  wire logic       running_in, // drive enabled
    input  wire logic       sec_tick_in,// one pulse per second
    input  wire logic [7:0] delay_in,   // delay in seconds
    output logic            expired_out // economy limit due
);
    logic [7:0] secs;
    always_ff @(posedge clk_in) begin
        if (!rstn_in || running_in) begin
            secs        <= '0;
            expired_out <= 1'b0;
        end else if (secs >= delay_in) begin
            expired_out <= 1'b1;
        end else if (sec_tick_in) begin
            secs <= secs + 8'h01;
        end
    end
endmodule : fcr_econ

//--- hdl/fcr_regulator.sv
// fcr_regulator: back-emf and field current loops with wishbone registers
// assumes feedback inputs synchronous to clk_in, scaled 0..1000
// Function
// - back-emf is armature voltage minus IR term, kept within 0..1000
// - demand from voltage loop, clamped between selected maximum and floor
// - back-emf below set point drives voltage loop to maximum
// - back-emf above set point lowers demand to regulate it
// - current error is demand minus field feedback, into current loop
// - current loop output is the firing angle, capped at front endstop
// - front endstop resets to 815
// - two maximum field values; a selector chooses the active one
// - economy timer picks lower maximum when drive is stopped
// - maximum selection by input pin or software bit
// - direct firing-angle mode bypasses both loops
// - set point at maximum makes demand equal selected maximum
// - spillover uses back-emf and emf set point
// - economy delay 0..255 seconds, default 30, counted from disable
// - auto economy bit hands selector to the timer
// - direct mode angle is the second maximum, capped by endstop
// - IR term is speed-error integral times factor over 2048
`timescale 1ns/1ps
module fcr_regulator
    import fcr_pkg::*;
#(
    parameter int SAMPLE_DIV = fcr_pkg::SAMPLE_CYCLES,
    parameter int SECOND_DIV = fcr_pkg::SECOND_CYCLES
) (
    input  wire logic               clk_in,       // 25 MHz clock
    input  wire logic               resetn_in,    // async reset, low active
    input  wire logic               wb_cyc_in,    // wishbone cycle
    input  wire logic               wb_stb_in,    // wishbone strobe
    input  wire logic               wb_we_in,     // write enable
    input  wire logic [7:0]         wb_adr_in,    // byte address
    input  wire logic [3:0]         wb_sel_in,    // byte lanes
    input  wire logic [31:0]        wb_dat_in,    // write data
    output logic [31:0]             wb_dat_out,   // read data
    output logic                    wb_ack_out,   // acknowledge
    input  wire logic [9:0]         arm_volt_in,  // armature voltage 0..1000
    input  wire logic signed [10:0] speed_int_in, // speed error integral +-1000
    input  wire logic [9:0]         field_fb_in,  // field current feedback
    input  wire logic               running_in,   // drive enabled
    input  wire logic               max2_pin_in,  // programmable input, max 2
    output logic [9:0]              angle_out,    // firing angle to pulse gen
    output logic                    angle_vld_out // new angle pulse
);
    import fcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic       rst_meta;
    logic       rstn;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta <= 1'b0;
            rstn     <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rstn     <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [4:0] ctrl;
    logic [9:0] emf_sp;
    logic [9:0] maxf1;
    logic [9:0] maxf2;
    logic [9:0] minf;
    logic [9:0] front;
    logic [7:0] econ_delay;
    logic [7:0] ir_factor;
    logic [9:0] bemf;
    logic [9:0] demand;
    logic       econ_expired;
    logic       sample_tick;
    logic       sec_tick;
    fcr_state_e state;

    wire        req       = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire        wr_req    = req && wb_we_in;
    wire        lane0     = wb_sel_in[0];
    wire        hit_ctrl  = wb_adr_in == REG_CTRL;
    wire        hit_sp    = wb_adr_in == REG_EMF_SP;
    wire        hit_max1  = wb_adr_in == REG_MAXF1;
    wire        hit_max2  = wb_adr_in == REG_MAXF2;
    wire        hit_min   = wb_adr_in == REG_MINF;
    wire        hit_front = wb_adr_in == REG_FRONT;
    wire        hit_econ  = wb_adr_in == REG_ECON;
    wire        hit_irf   = wb_adr_in == REG_IRF;

    // write strobes; byte-wide registers need lane 0
    wire        wr_ctrl   = wr_req && hit_ctrl && lane0;
    wire        wr_sp     = wr_req && hit_sp;
    wire        wr_max1   = wr_req && hit_max1;
    wire        wr_max2   = wr_req && hit_max2;
    wire        wr_min    = wr_req && hit_min;
    wire        wr_front  = wr_req && hit_front;
    wire        wr_econ   = wr_req && hit_econ && lane0;
    wire        wr_irf    = wr_req && hit_irf && lane0;

    wire        sel_auto = ctrl[CTRL_AUTO] ? econ_expired : ctrl[CTRL_SEL2];
    wire        use_max2 = ctrl[CTRL_PINSEL] ? max2_pin_in : sel_auto;
    wire [9:0]  max_sel  = use_max2 ? maxf2 : maxf1;

    // wide registers keep the high byte when its lane is not selected
    function automatic logic [9:0] wr10(input logic [9:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
        logic [9:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = d[7:0];
        end
        if (sel[1]) begin
            r[9:8] = d[9:8];
        end
        return (r > VAL_MAX) ? VAL_MAX : r;
    endfunction : wr10

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            ctrl <= '0;
        end else if (wr_ctrl) begin
            ctrl <= wb_dat_in[4:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            emf_sp <= EMF_SP_RST;
        end else if (wr_sp) begin
            emf_sp <= wr10(emf_sp, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            maxf1 <= MAXF1_RST;
        end else if (wr_max1) begin
            maxf1 <= wr10(maxf1, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            maxf2 <= MAXF2_RST;
        end else if (wr_max2) begin
            maxf2 <= wr10(maxf2, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            minf <= MINF_RST;
        end else if (wr_min) begin
            minf <= wr10(minf, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            front <= FRONT_RST;
        end else if (wr_front) begin
            front <= wr10(front, wb_dat_in, wb_sel_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            econ_delay <= ECON_RST;
        end else if (wr_econ) begin
            econ_delay <= wb_dat_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            ir_factor <= IRF_RST;
        end else if (wr_irf) begin
            ir_factor <= wb_dat_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_in)
            REG_CTRL:   rdata = {27'h0, ctrl[4:3], ctrl[2], ctrl[1], use_max2};
            REG_EMF_SP: rdata = {22'h0, emf_sp};
            REG_MAXF1:  rdata = {22'h0, maxf1};
            REG_MAXF2:  rdata = {22'h0, maxf2};
            REG_MINF:   rdata = {22'h0, minf};
            REG_FRONT:  rdata = {22'h0, front};
            REG_ECON:   rdata = {24'h0, econ_delay};
            REG_IRF:    rdata = {24'h0, ir_factor};
            REG_BEMF:   rdata = {22'h0, bemf};
            REG_DEMAND: rdata = {22'h0, demand};
            REG_ANGLE:  rdata = {22'h0, angle_out};
            REG_STATUS: rdata = {29'h0, econ_expired, use_max2, running_in};
            default:    rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= req;
        end
    end

    // read data stands only with ack, so an idle bus reads as zero
    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            wb_dat_out <= '0;
        end else begin
            wb_dat_out <= req ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample tick
    fcr_tick #(.DIV(SAMPLE_DIV)) u_sample (
        .clk_in   (clk_in),
        .rstn_in  (rstn),
        .clear_in (1'b0),
        .tick_out (sample_tick)
    );

    fcr_tick #(.DIV(SECOND_DIV)) u_second (
        .clk_in   (clk_in),
        .rstn_in  (rstn),
        .clear_in (running_in),
        .tick_out (sec_tick)
    );

    fcr_econ u_econ (
        .clk_in      (clk_in),
        .rstn_in     (rstn),
        .running_in  (running_in),
        .sec_tick_in (sec_tick),
        .delay_in    (econ_delay),
        .expired_out (econ_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // IR term
    wire signed [19:0] ir_prod = speed_int_in * $signed({1'b0, ir_factor});
    wire signed [23:0] ir_term = 24'(ir_prod >>> IR_SHIFT);
    wire signed [23:0] bemf_raw = $signed({14'h0, arm_volt_in}) - ir_term;
    wire [9:0]         bemf_next = fcr_clamp(bemf_raw, 10'h000, VAL_MAX);

    // voltage loop integrator, full scale means maximum demand
    logic signed [23:0] v_int;
    wire signed [23:0]  v_err  = $signed({14'h0, emf_sp}) - $signed({14'h0, bemf});
    wire signed [23:0]  v_sum  = v_int + (v_err >>> KI_SHIFT);
    wire signed [23:0]  v_prop = v_int + (v_err <<< KP_SHIFT);
    // set point at maximum forces full demand
    wire               v_full = (emf_sp == VAL_MAX) || (bemf < emf_sp);
    wire [9:0]         dem_next = v_full ? fcr_clamp({14'h0, max_sel}, minf, max_sel)
                                         : fcr_clamp(v_prop, minf, max_sel);
    wire [9:0]         v_int_sat  = fcr_clamp(v_sum, minf, max_sel);
    wire signed [23:0] next_v_int = v_full ? $signed({14'h0, max_sel})
                                           : $signed({14'h0, v_int_sat});

    ////////////////////////////////////////////////////////////////////////////
    // current error
    wire signed [23:0] i_err  = $signed({14'h0, demand}) - $signed({14'h0, field_fb_in});
    logic signed [23:0] i_int;
    wire signed [23:0] i_sum  = i_int + (i_err >>> KI_SHIFT);
    wire signed [23:0] i_out  = i_int + (i_err <<< KP_SHIFT);
    wire [9:0]         ang_loop = fcr_clamp(i_out, 10'h000, front);
    wire [9:0]         ang_dir  = fcr_clamp({14'h0, maxf2}, 10'h000, front);
    wire               loop_off   = ctrl[CTRL_DIRECT] || !ctrl[CTRL_ENABLE];
    wire [9:0]         ang_off    = ctrl[CTRL_DIRECT] ? ang_dir : 10'h000;
    wire [9:0]         next_angle = loop_off ? ang_off : ang_loop;
    wire [9:0]         i_int_sat  = fcr_clamp(i_sum, 10'h000, front);
    wire signed [23:0] next_i_int = loop_off ? 24'sh00_0000 : $signed({14'h0, i_int_sat});

    ////////////////////////////////////////////////////////////////////////////
    fcr_state_e next_state;
    always_comb begin
        next_state = FCR_IDLE;
        case (state)
            FCR_IDLE: next_state = sample_tick ? FCR_VOLT : FCR_IDLE;
            FCR_VOLT: next_state = FCR_CURR;
            FCR_CURR: next_state = FCR_IDLE;
            default:  next_state = FCR_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            state <= FCR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // state decode
    wire               st_volt = state == FCR_VOLT;
    wire               st_curr = state == FCR_CURR;

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            bemf   <= '0;
            demand <= '0;
            v_int  <= '0;
        end else if (st_volt) begin
            bemf   <= bemf_next;
            demand <= dem_next;
            v_int  <= next_v_int;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            angle_vld_out <= 1'b0;
        end else begin
            angle_vld_out <= st_curr;
        end
    end

    // angle moves only at an update pulse
    always_ff @(posedge clk_in) begin
        if (!rstn) begin
            i_int     <= '0;
            angle_out <= '0;
        end else if (st_curr) begin
            i_int     <= next_i_int;
            angle_out <= next_angle;
        end
    end
endmodule : fcr_regulator

//--- testbench/fcr_regulator_properties.sv
// fcr_regulator_properties: concurrent checks on the regulator ports
// assumes binding into fcr_regulator; sample period of at least 10 clocks
`timescale 1ns/1ps
module fcr_regulator_properties
    import fcr_pkg::*;
#(
    parameter int SAMPLE_DIV = 10,
    parameter int SECOND_DIV = 20
) (
    input wire logic               clk_in,
    input wire logic               resetn_in,
    input wire logic               wb_cyc_in,
    input wire logic               wb_stb_in,
    input wire logic               wb_we_in,
    input wire logic [7:0]         wb_adr_in,
    input wire logic [3:0]         wb_sel_in,
    input wire logic [31:0]        wb_dat_in,
    input wire logic [31:0]        wb_dat_out,
    input wire logic               wb_ack_out,
    input wire logic [9:0]         arm_volt_in,
    input wire logic signed [10:0] speed_int_in,
    input wire logic [9:0]         field_fb_in,
    input wire logic               running_in,
    input wire logic               max2_pin_in,
    input wire logic [9:0]         angle_out,
    input wire logic               angle_vld_out
);
    // checks start when the regulator's own two-flop reset copy releases
    logic [1:0] live;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            live <= 2'h0;
        end else begin
            live <= {live[0], 1'b1};
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!live[1]);
    wire rd_ack = wb_ack_out && !wb_we_in;
    ////////////////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not acknowledged next cycle");
    rdata_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data not zero outside ack");
    bemf_range_a: assert property (rd_ack && wb_adr_in == REG_BEMF |-> wb_dat_out <= 32'h3E8)
        else $error("back emf readout out of range");
    demand_range_a: assert property (rd_ack && wb_adr_in == REG_DEMAND |-> wb_dat_out <= 32'h3E8)
        else $error("demand readout out of range");
    unmapped_zero_a: assert property (rd_ack && wb_adr_in > REG_STATUS |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    angle_cap_a: assert property (angle_vld_out |-> angle_out <= VAL_MAX)
        else $error("firing angle above full scale");
    vld_spacing_a: assert property (angle_vld_out |=> !angle_vld_out [*8])
        else $error("angle updates closer than one sample");
    angle_hold_a: assert property ($changed(angle_out) |-> angle_vld_out)
        else $error("angle changed without update pulse");
    cover property (angle_vld_out && angle_out != 10'h000);
    cover property (wb_ack_out && wb_we_in);
    cover property (rd_ack && wb_adr_in == REG_BEMF);
endmodule : fcr_regulator_properties

bind fcr_regulator fcr_regulator_properties #(
    .SAMPLE_DIV(SAMPLE_DIV), .SECOND_DIV(SECOND_DIV)
) fcr_regulator_properties_inst (
    .clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .arm_volt_in, .speed_int_in, .field_fb_in,
    .running_in, .max2_pin_in, .angle_out, .angle_vld_out
);

//--- testbench/fcr_fire_model.sv
// fcr_fire_model: firing-pulse generator seen from the regulator
// assumes a new angle is offered with a one-cycle valid pulse
`timescale 1ns/1ps
module fcr_fire_model (
    input  wire logic       clk_in,   // control clock
    input  wire logic [9:0] angle_in, // firing angle
    input  wire logic       vld_in,   // new angle pulse
    output logic [9:0]      angle_out // angle the bridge fires at
);
    always_ff @(posedge clk_in) begin
        if (vld_in) begin
            angle_out <= angle_in;
        end
    end
endmodule : fcr_fire_model

//--- testbench/field_current_regulator_tb.sv
// field_current_regulator_tb: random and corner tests of the regulator
// assumes shortened sample and second dividers
`timescale 1ns/1ps
module field_current_regulator_tb;
    import fcr_pkg::*;
    localparam int SD = 10;
    localparam int SC = 20;
    logic clk_in = 0, resetn_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0;
    logic running_in = 0, max2_pin_in = 0, wb_ack_out, angle_vld_out;
    logic [7:0]  wb_adr_in = 8'h00;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
    logic [9:0]  arm_volt_in = 10'h000, field_fb_in = 10'h000, angle_out, fire_angle;
    logic signed [10:0] speed_int_in = 11'sh000;
    int fail_count = 0, tests_run = 0, v, f, s, fr;
    logic [7:0]  ra[8] = '{REG_EMF_SP, REG_MAXF1, REG_MAXF2, REG_MINF, REG_FRONT,
                           REG_ECON, REG_IRF, 8'h30};
    logic [31:0] re[8] = '{EMF_SP_RST, MAXF1_RST, MAXF2_RST, MINF_RST, FRONT_RST,
                           ECON_RST, IRF_RST, 32'h0};
    logic [4:0]  cc[4] = '{5'h08, 5'h09, 5'h18, 5'h18};
    always #20 clk_in = ~clk_in;
    fcr_regulator #(.SAMPLE_DIV(SD), .SECOND_DIV(SC)) fcr_regulator_inst (
        .clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .arm_volt_in, .speed_int_in, .field_fb_in,
        .running_in, .max2_pin_in, .angle_out, .angle_vld_out);
    fcr_fire_model fcr_fire_model_inst (
        .clk_in, .angle_in(angle_out), .vld_in(angle_vld_out), .angle_out(fire_angle));
    ////////////////////////////////////////////////////////////////////////////
    function automatic int bemf_exp(int a, int sp, int fc);
        int r;
        r = a - (sp * fc) / 2048;
        return r < 0 ? 0 : (r > 1000 ? 1000 : r);
    endfunction : bemf_exp
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : chk
    task automatic bus(logic we, logic [7:0] adr, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in} <= {2'b11, we, adr};
        {wb_dat_in, wb_sel_in} <= {d, 4'h3};
        // ack and read data are taken at the rising edge that shows ack high
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && n < 50);
        q = wb_dat_out;
        if (n >= 50) fail_count++;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
    endtask : bus
    task automatic tk(int n);
        repeat (n) @(posedge clk_in);
    endtask : tk
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tk(30000);
        fail_count++;
        conclude();
    end
    initial begin
        void'($urandom(32'hE2FC6879));
        tk(2);
        resetn_in <= 1'b1;
        tk(3);
        for (int i = 0; i < 8; i++) begin
            bus(0, ra[i], 0);
            chk("reset value", q, re[i]);
        end
        bus(1, REG_MAXF1, $urandom_range(1023, 1001));
        bus(0, REG_MAXF1, 0);
        chk("max1 saturate", q, 32'h3E8);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v = i ? $urandom_range(1000) : 0;
            f = i ? $urandom_range(255) : 255;
            s = i ? $urandom_range(1000) : 1000;
            bus(1, REG_IRF, f);
            arm_volt_in <= v;
            speed_int_in <= s;
            tk(3 * SD);
            bus(0, REG_BEMF, 0);
            chk("back emf", q, bemf_exp(v, s, f));
        end
        bus(1, REG_IRF, 0);
        $display("test back emf done");
        for (int i = 0; i < 4; i++) begin
            bus(1, REG_CTRL, cc[i]);
            max2_pin_in <= (i == 2);
            tk(3 * SD);
            bus(0, REG_DEMAND, 0);
            chk("selected maximum", q, (i == 1 || i == 2) ? 500 : 1000);
        end
        arm_volt_in <= 300;
        bus(1, REG_EMF_SP, $urandom_range(999, 301));
        tk(3 * SD);
        bus(0, REG_DEMAND, 0);
        chk("demand below set point", q, 1000);
        arm_volt_in <= 900;
        bus(1, REG_EMF_SP, 100);
        tk(60 * SD);
        bus(0, REG_DEMAND, 0);
        chk("demand weakened", q < 1000 && q >= 500, 1);
        bus(1, REG_EMF_SP, 1000);
        $display("test voltage loop done");
        tk(100 * SD);
        chk("angle at endstop", angle_out, FRONT_RST);
        chk("bridge angle", fire_angle, FRONT_RST);
        fr = $urandom_range(814, 400);
        bus(1, REG_FRONT, fr);
        tk(100 * SD);
        chk("programmed endstop", angle_out, fr);
        field_fb_in <= 1000;
        bus(1, REG_CTRL, 5'h09);
        tk(100 * SD);
        chk("angle backed off", angle_out < fr, 1);
        for (int i = 0; i < 3; i++) begin
            v = i ? $urandom_range(1000) : 1000;
            bus(1, REG_MAXF2, v);
            bus(1, REG_CTRL, 5'h0C);
            tk(3 * SD);
            chk("direct angle", fire_angle, v < fr ? v : fr);
        end
        bus(1, REG_CTRL, 5'h00);
        tk(3 * SD);
        chk("field control off", angle_out, 10'h000);
        bus(1, REG_MAXF2, 500);
        $display("test current loop done");
        running_in <= 1'b1;
        bus(1, REG_ECON, 2);
        bus(1, REG_CTRL, 5'h0A);
        tk(3 * SC);
        running_in <= 1'b0;
        tk(SC / 2);
        bus(0, REG_STATUS, 0);
        chk("economy not yet", q[1], 0);
        tk(3 * SC);
        bus(0, REG_STATUS, 0);
        chk("economy selected", q[2:1], 2'b11);
        bus(0, REG_DEMAND, 0);
        chk("economy demand", q, 500);
        running_in <= 1'b1;
        tk(3 * SD);
        bus(0, REG_STATUS, 0);
        chk("economy cleared", q[1], 0);
        $display("test economy done");
        conclude();
    end
endmodule : field_current_regulator_tb
